// file: design/nia_pkg.sv
// nia_pkg: constants and carrier types for the interrupt aggregator
package nia_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] NIA_OFS_CSR       = 8'h04;
  localparam logic [7:0] NIA_OFS_SRC       = 8'h08;
  localparam logic [7:0] NIA_OFS_MASK      = 8'h0c;
  localparam logic [7:0] NIA_OFS_HW_SRC    = 8'h10;
  localparam logic [7:0] NIA_OFS_HW_MASK   = 8'h14;
  localparam logic [7:0] NIA_OFS_MIRROR1   = 8'h18;
  localparam logic [7:0] NIA_OFS_MIRROR2   = 8'h1c;
  localparam logic [7:0] NIA_OFS_MIRROR3   = 8'h20;
  localparam logic [7:0] NIA_OFS_ENTER     = 8'h24;
  localparam logic [7:0] NIA_OFS_LEAVE     = 8'h28;
  localparam logic [7:0] NIA_OFS_CTRL      = 8'h2c;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int NIA_SRC_HW_ERR   = 31;
  localparam int NIA_SRC_BURST    = 30;
  localparam int NIA_SRC_POLL     = 27;
  localparam int NIA_SRC_TWO_WIRE = 26;
  localparam int NIA_SRC_SW       = 25;
  localparam int NIA_SRC_TIMER    = 24;
  localparam int NIA_SRC_PHY      = 4;
  localparam int NIA_SRC_MAC      = 3;
  localparam int NIA_SRC_RX_DESC  = 2;
  localparam int NIA_SRC_TX_DESC  = 0;
  localparam int NIA_HW_TS_OVF    = 29;
  localparam int NIA_HW_SENSOR    = 28;
  localparam int NIA_HW_MASTER    = 27;
  localparam int NIA_HW_STATUS    = 26;
  localparam int NIA_HW_UNCORR    = 25;
  localparam int NIA_HW_INT_MODE  = 24;
  localparam int NIA_HW_MAC_PAR   = 3;
  localparam int NIA_HW_RXQ_PAR   = 2;
  localparam int NIA_HW_SEG_LEN   = 0;
  localparam int NIA_CSR_SW_SET   = 7;
  localparam int NIA_CSR_SW_CLR   = 6;
  localparam int NIA_CTRL_MASK    = 3;
  localparam int NIA_CTRL_STATUS  = 2;
  localparam int NIA_CTRL_LEAVE   = 1;
  localparam int NIA_CTRL_ENTER   = 0;

  // ------------------------------------------------------------
  // implemented bits and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] NIA_SRC_VALID = 32'hcf00_001d;
  localparam logic [31:0] NIA_HW_VALID  = 32'h3f00_000d;
  localparam logic [31:0] NIA_RST_WORD  = 32'h0000_0000;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } nia_req_t;

  typedef struct packed {
    logic status_burst_event;
    logic poller_check_event;
    logic two_wire_done_event;
    logic interrupt_timer_event;
  } nia_gen_ev_t;

  typedef struct packed {
    logic phy_event;
    logic mac_event;
    logic rx_descriptor_coding_error;
    logic async_tx_descriptor_coding_error;
  } nia_port_ev_t;

  typedef struct packed {
    logic timestamp_overflow;
    logic sensor_event;
    logic data_parity_error_flag;
    logic received_target_abort_flag;
    logic received_master_abort_flag;
    logic parity_error_flag;
    logic uncorrectable_link_error;
    logic internal_mode_error;
    logic mac_parity_fault;
    logic rxq_parity_fault;
    logic segmentation_length_mismatch;
  } nia_hw_ev_t;

endpackage

// file: design/nia_top.sv
// nia_top: interrupt sources, masks, mirrors and service-mode control
//
// Operation
// - source bits read one while pending; writes ignored; cleared by reset
// - source bit 31 set while any enabled hardware-error bit is active
// - general bits 30 burst, 27 poller, 26 two-wire, 25 software, 24 timer
// - port bits 4 phy, 3 mac, 2 rx descriptor, 0 tx descriptor
// - mask bit one lets its source onto request line; resets zero
// - hardware-error bit 29 timestamp overflow, bit 28 sensor interrupt
// - hardware-error bit 27 on data parity, target or master abort
// - hardware-error bit 26 on any of four bus status flags
// - bit 25 uncorrectable link errors, bit 24 internal mode error
// - bit 3 mac parity, bit 2 rx queue parity, bit 0 length mismatch
// - hardware-error mask bit one enables error toward host line
// - mask bits of absent second mac stored but without effect
// - mirrors return source while request asserted, else zero; writes ignored
// - mirror one or two read with request asserted masks everything
// - mirror two read with request asserted also enters service mode
// - mirror three read always masks; service mode only if request asserted
// - enter register read sets service mode, masks, returns source
// - leave register read clears service mode, unmasks, returns source
// - control bit 3 reads mask flag, bit 2 service flag; rest zero
// - control bit 1 written one leaves service mode and unmasks unless bit 0 is also one
// - control bit 0 written one enters service mode and masks
// - csr bit 7 sets, bit 6 clears software interrupt; both ignored
`timescale 1ns/1ps

module nia_top
  import nia_pkg::*;
(
  // clock and resets
  input  wire logic         CLK_SYS,
  input  wire logic         RST_B,
  input  wire logic         SW_RST,
  // register port
  input  wire nia_req_t     REG_REQ,
  output logic [31:0]       REG_RDATA,
  output logic              REG_RVALID,
  // event sources
  input  wire nia_gen_ev_t  GEN_EVENTS,
  input  wire nia_port_ev_t PORT_EVENTS,
  input  wire nia_hw_ev_t   HW_EVENTS,
  // interrupt outputs
  output logic              IRQ_REQ,
  output logic              HOST_INT_B
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic hit(input nia_req_t r, input logic [7:0] ofs);
    hit = (r.addr == ofs);
  endfunction

  logic        rd_m1, rd_m2, rd_m3, rd_enter, rd_leave;
  logic        wr_csr, wr_mask, wr_hw_mask, wr_ctrl;
  logic [31:0] src_q, src_d;
  logic [31:0] hw_src_q, hw_src_d;
  logic [31:0] mask_q, hw_mask_q;
  logic        sw_q, isr_mask_q, isr_status_q, irq_d;
  logic        set_mask, set_status, release_svc;

  assign rd_m1      = REG_REQ.rd && hit(REG_REQ, NIA_OFS_MIRROR1);
  assign rd_m2      = REG_REQ.rd && hit(REG_REQ, NIA_OFS_MIRROR2);
  assign rd_m3      = REG_REQ.rd && hit(REG_REQ, NIA_OFS_MIRROR3);
  assign rd_enter   = REG_REQ.rd && hit(REG_REQ, NIA_OFS_ENTER);
  assign rd_leave   = REG_REQ.rd && hit(REG_REQ, NIA_OFS_LEAVE);
  assign wr_csr     = REG_REQ.wr && hit(REG_REQ, NIA_OFS_CSR);
  assign wr_mask    = REG_REQ.wr && hit(REG_REQ, NIA_OFS_MASK);
  assign wr_hw_mask = REG_REQ.wr && hit(REG_REQ, NIA_OFS_HW_MASK);
  assign wr_ctrl    = REG_REQ.wr && hit(REG_REQ, NIA_OFS_CTRL);

  // ------------------------------------------------------------
  // hardware-error source
  // ------------------------------------------------------------
  always_comb begin
    hw_src_d = NIA_RST_WORD;
    hw_src_d[NIA_HW_TS_OVF]   = HW_EVENTS.timestamp_overflow;
    hw_src_d[NIA_HW_SENSOR]   = HW_EVENTS.sensor_event;
    hw_src_d[NIA_HW_MASTER]   = HW_EVENTS.data_parity_error_flag
                              | HW_EVENTS.received_target_abort_flag
                              | HW_EVENTS.received_master_abort_flag;
    hw_src_d[NIA_HW_STATUS]   = HW_EVENTS.parity_error_flag
                              | HW_EVENTS.received_master_abort_flag
                              | HW_EVENTS.received_target_abort_flag
                              | HW_EVENTS.data_parity_error_flag;
    hw_src_d[NIA_HW_UNCORR]   = HW_EVENTS.uncorrectable_link_error;
    hw_src_d[NIA_HW_INT_MODE] = HW_EVENTS.internal_mode_error;
    hw_src_d[NIA_HW_MAC_PAR]  = HW_EVENTS.mac_parity_fault;
    hw_src_d[NIA_HW_RXQ_PAR]  = HW_EVENTS.rxq_parity_fault;
    hw_src_d[NIA_HW_SEG_LEN]  = HW_EVENTS.segmentation_length_mismatch;
  end

  // ------------------------------------------------------------
  // general and port source
  // ------------------------------------------------------------
  always_comb begin
    src_d = NIA_RST_WORD;
    src_d[NIA_SRC_HW_ERR]   =
      |(hw_src_d & hw_mask_q & NIA_HW_VALID);
    src_d[NIA_SRC_BURST]    = GEN_EVENTS.status_burst_event;
    src_d[NIA_SRC_POLL]     = GEN_EVENTS.poller_check_event;
    src_d[NIA_SRC_TWO_WIRE] = GEN_EVENTS.two_wire_done_event;
    src_d[NIA_SRC_SW]       = sw_q;
    src_d[NIA_SRC_TIMER]    = GEN_EVENTS.interrupt_timer_event;
    src_d[NIA_SRC_PHY]      = PORT_EVENTS.phy_event;
    src_d[NIA_SRC_MAC]      = PORT_EVENTS.mac_event;
    src_d[NIA_SRC_RX_DESC]  = PORT_EVENTS.rx_descriptor_coding_error;
    src_d[NIA_SRC_TX_DESC]  =
      PORT_EVENTS.async_tx_descriptor_coding_error;
  end

  // sources follow their events every cycle, never written
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      src_q    <= NIA_RST_WORD;
      hw_src_q <= NIA_RST_WORD;
    end else if (SW_RST) begin
      src_q    <= NIA_RST_WORD;
      hw_src_q <= NIA_RST_WORD;
    end else begin
      src_q    <= src_d;
      hw_src_q <= hw_src_d;
    end
  end

  // ------------------------------------------------------------
  // enable masks
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      mask_q    <= NIA_RST_WORD;
      hw_mask_q <= NIA_RST_WORD;
    end else if (SW_RST) begin
      mask_q    <= NIA_RST_WORD;
      hw_mask_q <= NIA_RST_WORD;
    end else begin
      if (wr_mask) begin
        mask_q <= REG_REQ.wdata;
      end
      if (wr_hw_mask) begin
        hw_mask_q <= REG_REQ.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // software interrupt request
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sw_q <= 1'b0;
    end else if (SW_RST) begin
      sw_q <= 1'b0;
    end else if (wr_csr) begin
      unique case ({REG_REQ.wdata[NIA_CSR_SW_SET],
                    REG_REQ.wdata[NIA_CSR_SW_CLR]})
        2'b10: sw_q <= 1'b1;
        2'b01: sw_q <= 1'b0;
        2'b00,
        2'b11: sw_q <= sw_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // global mask and service mode
  // ------------------------------------------------------------
  assign set_mask    = ((rd_m1 || rd_m2) && IRQ_REQ)
                     || rd_m3 || rd_enter
                     || (wr_ctrl && REG_REQ.wdata[NIA_CTRL_ENTER]);
  assign set_status  = ((rd_m2 || rd_m3) && IRQ_REQ) || rd_enter
                     || (wr_ctrl && REG_REQ.wdata[NIA_CTRL_ENTER]);
  assign release_svc = rd_leave
                     || (wr_ctrl && REG_REQ.wdata[NIA_CTRL_LEAVE]);

  // entering wins over leaving when both arrive together
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      isr_mask_q   <= 1'b0;
      isr_status_q <= 1'b0;
    end else if (SW_RST) begin
      isr_mask_q   <= 1'b0;
      isr_status_q <= 1'b0;
    end else begin
      if (set_mask) begin
        isr_mask_q <= 1'b1;
      end else if (release_svc) begin
        isr_mask_q <= 1'b0;
      end
      if (set_status) begin
        isr_status_q <= 1'b1;
      end else if (release_svc) begin
        isr_status_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // request line and host line
  // ------------------------------------------------------------
  always_comb begin
    irq_d = |(src_q & mask_q & NIA_SRC_VALID) && !isr_mask_q;
    if (set_mask || SW_RST) begin
      irq_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      IRQ_REQ    <= 1'b0;
      HOST_INT_B <= 1'b1;
    end else begin
      IRQ_REQ    <= irq_d;
      HOST_INT_B <= !irq_d;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA  <= NIA_RST_WORD;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
      REG_RDATA  <= NIA_RST_WORD;
      if (REG_REQ.rd) begin
        unique case (REG_REQ.addr)
          NIA_OFS_CSR: begin
            REG_RDATA[NIA_CSR_SW_SET] <= sw_q;
            REG_RDATA[NIA_CSR_SW_CLR] <= !sw_q;
          end
          NIA_OFS_SRC:     REG_RDATA <= src_q;
          NIA_OFS_MASK:    REG_RDATA <= mask_q;
          NIA_OFS_HW_SRC:  REG_RDATA <= hw_src_q;
          NIA_OFS_HW_MASK: REG_RDATA <= hw_mask_q;
          NIA_OFS_MIRROR1,
          NIA_OFS_MIRROR2,
          NIA_OFS_MIRROR3: begin
            REG_RDATA <= IRQ_REQ ? src_q : NIA_RST_WORD;
          end
          NIA_OFS_ENTER:   REG_RDATA <= src_q;
          NIA_OFS_LEAVE:   REG_RDATA <= src_q;
          NIA_OFS_CTRL: begin
            REG_RDATA[NIA_CTRL_MASK]   <= isr_mask_q;
            REG_RDATA[NIA_CTRL_STATUS] <= isr_status_q;
          end
          default:         REG_RDATA <= NIA_RST_WORD;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B || SW_RST);

  a_src_follows: assert property (
    ##1 (src_q[NIA_SRC_BURST] == $past(GEN_EVENTS.status_burst_event)))
    else $error("source bit 30 does not follow its event");

  a_hw_summary: assert property (
    ##1 (src_q[NIA_SRC_HW_ERR] ==
         |(hw_src_q & $past(hw_mask_q) & NIA_HW_VALID)))
    else $error("hardware summary bit wrong");

  a_master_err: assert property (
    HW_EVENTS.received_master_abort_flag |=>
      hw_src_q[NIA_HW_MASTER] && hw_src_q[NIA_HW_STATUS])
    else $error("master abort not flagged");

  a_mirror_zero: assert property (
    (rd_m1 || rd_m2 || rd_m3) && !IRQ_REQ |=> REG_RDATA == 32'h0000_0000)
    else $error("mirror read not zero while idle");

  a_mirror1_mask: assert property (
    rd_m1 && IRQ_REQ |=> isr_mask_q && !IRQ_REQ)
    else $error("mirror one read did not mask");

  a_mirror2_svc: assert property (
    rd_m2 && IRQ_REQ |=> isr_status_q && isr_mask_q)
    else $error("mirror two read did not enter service");

  a_mirror3_mask: assert property (
    rd_m3 |=> isr_mask_q && !IRQ_REQ ##1 !IRQ_REQ)
    else $error("mirror three read did not mask");

  a_enter_read: assert property (
    rd_enter |=> isr_status_q && isr_mask_q && REG_RDATA == $past(src_q))
    else $error("enter read wrong");

  a_leave_read: assert property (
    rd_leave && !set_mask && !set_status |=> !isr_status_q && !isr_mask_q)
    else $error("leave read did not release");

  a_ctrl_zero: assert property (
    REG_REQ.rd && hit(REG_REQ, NIA_OFS_CTRL) |=>
      REG_RDATA[31:4] == 28'h0 && REG_RDATA[1:0] == 2'h0)
    else $error("control reserved bits not zero");

  a_sw_both: assert property (
    wr_csr && REG_REQ.wdata[7:6] == 2'b11 |=> $stable(sw_q))
    else $error("software set and clear together changed state");

  a_masked_idle: assert property (
    isr_mask_q |=> !IRQ_REQ)
    else $error("request while globally masked");

  a_irq_enabled: assert property (
    src_q[NIA_SRC_PHY] && mask_q[NIA_SRC_PHY] && !isr_mask_q && !set_mask
      |=> IRQ_REQ)
    else $error("enabled source did not raise request");

  a_irq_none: assert property (
    (src_q & mask_q & NIA_SRC_VALID) == 32'h0 |=> !IRQ_REQ)
    else $error("request without enabled source");

  a_host_line: assert property (
    HOST_INT_B == !IRQ_REQ)
    else $error("host line not inverse of request");

  a_hw_timestamp: assert property (
    HW_EVENTS.timestamp_overflow |=> hw_src_q[NIA_HW_TS_OVF])
    else $error("timestamp overflow not flagged");

  a_hw_status: assert property (
    HW_EVENTS.parity_error_flag |=> hw_src_q[NIA_HW_STATUS])
    else $error("parity error status not flagged");

  a_hw_panic: assert property (
    HW_EVENTS.rxq_parity_fault |=> hw_src_q[NIA_HW_RXQ_PAR])
    else $error("rx queue parity fault not flagged");

  a_port_phy: assert property (
    PORT_EVENTS.phy_event |=> src_q[NIA_SRC_PHY])
    else $error("phy event not flagged");

  a_gen_timer: assert property (
    GEN_EVENTS.interrupt_timer_event |=> src_q[NIA_SRC_TIMER])
    else $error("timer event not flagged");

  a_sw_set: assert property (
    wr_csr && REG_REQ.wdata[NIA_CSR_SW_SET] && !REG_REQ.wdata[NIA_CSR_SW_CLR]
      |=> sw_q ##1 src_q[NIA_SRC_SW])
    else $error("software interrupt not set");

  a_sw_clear: assert property (
    wr_csr && !REG_REQ.wdata[NIA_CSR_SW_SET] && REG_REQ.wdata[NIA_CSR_SW_CLR]
      |=> !sw_q)
    else $error("software interrupt not cleared");

  a_ctrl_enter: assert property (
    wr_ctrl && REG_REQ.wdata[NIA_CTRL_ENTER]
      |=> isr_mask_q && isr_status_q && !IRQ_REQ)
    else $error("control enter did not mask");

  a_ctrl_leave: assert property (
    wr_ctrl && REG_REQ.wdata[NIA_CTRL_LEAVE] && !REG_REQ.wdata[NIA_CTRL_ENTER]
      |=> !isr_mask_q && !isr_status_q)
    else $error("control leave did not release");

  a_mirror_data: assert property (
    (rd_m1 || rd_m2 || rd_m3) && IRQ_REQ |=> REG_RDATA == $past(src_q))
    else $error("mirror read not source while requesting");

  a_mask_write: assert property (
    wr_mask |=> mask_q == $past(REG_REQ.wdata))
    else $error("mask write not stored");

  a_hw_mask_write: assert property (
    wr_hw_mask |=> hw_mask_q == $past(REG_REQ.wdata))
    else $error("error mask write not stored");

  a_ctrl_read: assert property (
    REG_REQ.rd && hit(REG_REQ, NIA_OFS_CTRL) |=>
      REG_RDATA[NIA_CTRL_MASK] == $past(isr_mask_q) &&
      REG_RDATA[NIA_CTRL_STATUS] == $past(isr_status_q))
    else $error("control flags read wrong");

  a_hw_reserved: assert property (
    (hw_mask_q & NIA_HW_VALID) == 32'h0 |=> !src_q[NIA_SRC_HW_ERR])
    else $error("unused error mask bit raised summary");

endmodule // nia_top

// file: verification/nia_host_model.sv
// nia_host_model: host side that samples the legacy interrupt line
`timescale 1ns/1ps

module nia_host_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // interrupt line
  input  wire logic host_int_b,
  // host view
  output logic      int_seen
);
  // ----------------------------------------------------------
  // level-sensitive sampling of the active-low line
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_seen <= 1'b0;
    end else begin
      int_seen <= ~host_int_b;
    end
  end
endmodule // nia_host_model

// file: verification/tb.sv
// tb: self-checking bench for the interrupt aggregator
`timescale 1ns/1ps

module tb
  import nia_pkg::*;
;
  logic        clk, rst_b, sw_rst, rvalid, irq_req, host_int_b, int_seen;
  nia_req_t    req;
  logic [31:0] rdata, m_mask, m_hwmask;
  logic [3:0]  gen, port;
  logic [10:0] hw;
  logic        m_sw, m_imask, m_istat;
  int          fails, n_compared, cycles;
  integer      seed;

  nia_top nia_top_inst (
    .CLK_SYS     (clk),
    .RST_B       (rst_b),
    .SW_RST      (sw_rst),
    .REG_REQ     (req),
    .REG_RDATA   (rdata),
    .REG_RVALID  (rvalid),
    .GEN_EVENTS  (nia_gen_ev_t'(gen)),
    .PORT_EVENTS (nia_port_ev_t'(port)),
    .HW_EVENTS   (nia_hw_ev_t'(hw)),
    .IRQ_REQ     (irq_req),
    .HOST_INT_B  (host_int_b)
  );

  nia_host_model nia_host_model_inst (
    .clk        (clk),
    .rst_b      (rst_b),
    .host_int_b (host_int_b),
    .int_seen   (int_seen)
  );

  always #20 clk = ~clk;

  // ----------------------------------------------------------
  // reference model
  // ----------------------------------------------------------
  function automatic logic [31:0] hw_src();
    logic [31:0] v;
    v = '0;
    v[29] = hw[10];
    v[28] = hw[9];
    v[27] = |hw[8:6];
    v[26] = |hw[8:5];
    v[25] = hw[4];
    v[24] = hw[3];
    v[3] = hw[2];
    v[2] = hw[1];
    v[0] = hw[0];
    return v;
  endfunction

  function automatic logic [31:0] src();
    logic [31:0] v;
    v = '0;
    v[31] = |(hw_src() & m_hwmask & 32'h3f00_000d);
    v[30] = gen[3];
    v[27] = gen[2];
    v[26] = gen[1];
    v[25] = m_sw;
    v[24] = gen[0];
    v[4] = port[3];
    v[3] = port[2];
    v[2] = port[1];
    v[0] = port[0];
    return v;
  endfunction

  function automatic logic m_irq();
    return (|(src() & m_mask & 32'hcf00_001d)) && !m_imask;
  endfunction

  function automatic logic [31:0] rd_exp(input logic [7:0] a);
    case (a)
      8'h04: return {24'h0, m_sw, ~m_sw, 6'h0};
      8'h08, 8'h24, 8'h28: return src();
      8'h0c: return m_mask;
      8'h10: return hw_src();
      8'h14: return m_hwmask;
      8'h18, 8'h1c, 8'h20: return m_irq() ? src() : 32'h0;
      8'h2c: return {28'h0, m_imask, m_istat, 2'b00};
      default: return 32'h0;
    endcase
  endfunction

  task automatic model_op(input logic is_rd, input logic [7:0] a,
                          input logic [31:0] d);
    logic irq;
    irq = m_irq();
    if (is_rd) begin
      case (a)
        8'h18: if (irq) m_imask = 1'b1;
        8'h1c: if (irq) {m_imask, m_istat} = 2'b11;
        8'h20: begin
          m_imask = 1'b1;
          if (irq) m_istat = 1'b1;
        end
        8'h24: {m_imask, m_istat} = 2'b11;
        8'h28: {m_imask, m_istat} = 2'b00;
        default: ;
      endcase
    end else begin
      case (a)
        8'h04: if (d[7] != d[6]) m_sw = d[7];
        8'h0c: m_mask = d;
        8'h14: m_hwmask = d;
        8'h2c: begin
          if (d[0]) {m_imask, m_istat} = 2'b11;
          else if (d[1]) {m_imask, m_istat} = 2'b00;
        end
        default: ;
      endcase
    end
  endtask

  // ----------------------------------------------------------
  // compare, stimulus and closing tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic access(input logic is_rd, input logic [7:0] a,
                        input logic [31:0] d);
    logic [31:0] e;
    e = rd_exp(a);
    req = '{rd: is_rd, wr: ~is_rd, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    model_op(is_rd, a, d);
    if (is_rd) begin
      chk({31'h0, rvalid}, 32'h1);
      chk(rdata, e);
      if (m_imask) chk({31'h0, irq_req}, 32'h0);
    end else begin
      chk({31'h0, rvalid}, 32'h0);
      chk(rdata, 32'h0);
    end
    repeat (3) @(negedge clk);
    chk({31'h0, irq_req}, {31'h0, m_irq()});
    chk({31'h0, host_int_b}, {31'h0, ~m_irq()});
    chk({31'h0, int_seen}, {31'h0, m_irq()});
  endtask

  task automatic ev(input logic [31:0] v);
    gen = v[3:0];
    port = v[7:4];
    hw = v[18:8];
    repeat (3) @(negedge clk);
  endtask

  task automatic results();
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [31:0] op;
    clk = 1'b0;
    rst_b = 1'b0;
    sw_rst = 1'b0;
    req = '0;
    {gen, port, hw} = '0;
    {m_mask, m_hwmask, m_sw, m_imask, m_istat} = '0;
    {fails, n_compared, cycles} = '0;
    seed = 32'h0e60dc79;
    repeat (16) @(negedge clk);
    chk({29'h0, host_int_b, irq_req, rvalid}, 32'h4);
    chk(rdata, 32'h0);
    rst_b = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 12; i++) access(1'b1, 8'(4 + 4 * i), '0);
    ev(32'hffff_ffff);
    access(1'b0, 8'h0c, 32'hffff_ffff);
    access(1'b0, 8'h14, 32'hffff_ffff);
    for (int i = 0; i < 9; i++) access(1'b0, 8'(8 + 8 * (i % 2) + 4 * i), '1);
    for (int i = 0; i < 12; i++) access(1'b1, 8'(4 + 4 * i), '0);
    for (int i = 0; i < 700; i++) begin
      if (($random(seed) & 3) == 0) ev($random(seed) & $random(seed));
      op = $random(seed);
      access(op[4], {2'b00, op[3:0], 2'b00}, $random(seed));
    end
    ev(32'h0);
    access(1'b0, 8'h04, 32'h0000_0080);
    access(1'b0, 8'h0c, 32'hffff_ffff);
    access(1'b0, 8'h2c, 32'h0000_0003);
    access(1'b0, 8'h2c, 32'h0000_0002);
    access(1'b0, 8'h04, 32'h0000_00c0);
    access(1'b1, 8'h04, '0);
    sw_rst = 1'b1;
    @(negedge clk);
    sw_rst = 1'b0;
    {m_mask, m_hwmask, m_sw, m_imask, m_istat} = '0;
    @(negedge clk);
    for (int i = 0; i < 11; i++) access(1'b1, 8'(4 + 4 * i), '0);
    results();
  end
endmodule // tb
